/* File: core/fwp_pkg.sv */
// Purpose: Shared constants and types of the flash write-protection block.
// Assumes: Serial commands arrive in single-bit mode with three address bytes.
// Notes: Status bit positions, opcodes and block counts are named here once.
package fwp_pkg;
	// Status register bit positions, then the selector and bank bits.
	localparam int unsigned SR_BUSY = 0;
	localparam int unsigned SR_WEL = 1;
	localparam int unsigned SR_LVL_LSB = 2;
	localparam int unsigned SR_QE = 6;
	localparam int unsigned SR_LOCK = 7;
	localparam int unsigned FR_TBS = 1;
	localparam int unsigned BANK_A24 = 0;
	// Reset values.
	localparam logic [3:0] LVL_RST = 4'h0;
	localparam logic [7:0] PARAM_RST = 8'h00;
	localparam logic [4:0] SYNC_RST = 5'h10;
	// Command codes.
	localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OPC_WRDI = 8'h04;
	localparam logic [7:0] OPC_RDSR = 8'h05;
	localparam logic [7:0] OPC_STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] OPC_WRFR = 8'h42;
	localparam logic [7:0] OPC_PARV_FREE = 8'hC0;
	localparam logic [7:0] OPC_PARV = 8'h63;
	localparam logic [7:0] OPC_BANKV_FREE = 8'h17;
	localparam logic [7:0] OPC_BANKV = 8'hC5;
	localparam logic [7:0] OPC_PP = 8'h02;
	localparam logic [7:0] OPC_SE = 8'h20;
	localparam logic [7:0] OPC_SE_ALT = 8'hD7;
	localparam logic [7:0] OPC_BE32 = 8'h52;
	localparam logic [7:0] OPC_BE64 = 8'hD8;
	localparam logic [7:0] OPC_CE = 8'hC7;
	localparam logic [7:0] OPC_CE_ALT = 8'h60;
	// Block geometry.
	localparam logic [9:0] BLOCKS_64K = 10'h200;
	localparam logic [9:0] BLOCKS_256K = 10'h080;
	localparam int unsigned LVL_LAST_POW = 9;
	localparam logic [3:0] LVL_ALL = 4'hF;

	typedef enum logic [1:0] {FWP_PROG, FWP_SECT, FWP_BLOCK, FWP_CHIP} fwp_kind_t;
	typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_SKIP} fwp_phase_t;

	typedef struct packed {
		logic valid;
		fwp_kind_t kind;
		logic [24:0] addr;
	} fwp_op_t;

	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic sck_prev;
		logic cs_prev;
		fwp_phase_t phase;
		logic [4:0] bits;
		logic [7:0] opc;
		logic opc_ok;
		logic [23:0] addr;
		logic addr_ok;
		logic [7:0] data;
		logic data_ok;
		logic [7:0] shift;
		logic write_enable_latch;
		logic [3:0] lvl;
		logic qe;
		logic lock;
		logic top_bottom_select;
		logic [7:0] rdpar;
		logic [7:0] bank;
		fwp_op_t op;
		logic reject;
		logic so;
		logic so_oe_n;
		logic quad;
	} fwp_state_t;
endpackage : fwp_pkg

/* File: core/fwp_core.sv */
// Purpose: Serial command front end that keeps block protection and status-register locking.
// Assumes: Serial clock, select and pins are asynchronous and are sampled by clk_i.
// Notes: Granted program and erase requests leave as one-cycle pulses on op_o.
`timescale 1ns/1ns

module fwp_core #(
	parameter bit BIG_BLOCKS = 1'b0
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Serial link pins.
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_n_o,
	// Protect or third data line.
	input wire logic data_line_third_i,
	output logic data_line_third_o,
	output logic data_line_third_oe_n_o,
	// Hold or fourth data line.
	input wire logic data_line_fourth_i,
	output logic data_line_fourth_o,
	output logic data_line_fourth_oe_n_o,
	// Array side.
	input wire logic busy_i,
	output fwp_pkg::fwp_op_t op_o,
	output logic reject_o,
	// Configuration view.
	output logic [7:0] status_o,
	output logic quad_mode_o,
	output logic top_bottom_select_o,
	output logic [7:0] read_params_o,
	output logic [7:0] bank_addr_o
);
	fwp_pkg::fwp_state_t st_q;
	fwp_pkg::fwp_state_t st_d;
	logic cs_n;
	logic sck;
	logic si;
	logic wp_low;
	logic hold_act;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic cs_fall;
	logic [7:0] sr_view;
	logic [24:0] full_addr;
	logic lvl_zero;

	// Number of protected blocks for a level, counted from the selected end.
	function automatic logic [9:0] prot_count(input logic [3:0] lvl);
		logic [9:0] n;
		n = 10'h000;
		if (BIG_BLOCKS) begin
			if (lvl[3]) begin
				n = fwp_pkg::BLOCKS_256K;
			end else if (lvl != 4'h0) begin
				n = 10'(10'h001 << (lvl - 4'h1));
			end
		end else if (lvl == fwp_pkg::LVL_ALL) begin
			n = fwp_pkg::BLOCKS_64K;
		end else if (lvl > 4'(fwp_pkg::LVL_LAST_POW)) begin
			n = 10'(fwp_pkg::BLOCKS_64K - (10'h001 << (5'd17 - 5'(lvl))));
		end else if (lvl != 4'h0) begin
			n = 10'(10'h001 << (lvl - 4'h1));
		end
		return n;
	endfunction : prot_count

	// True when the block holding the address lies in the protected range.
	function automatic logic prot_hit(input logic [3:0] lvl, input logic top_bottom_select, input logic [24:0] a);
		logic [9:0] blk;
		logic [9:0] total;
		logic [9:0] n;
		blk = BIG_BLOCKS ? {3'h0, a[24:18]} : {1'b0, a[24:16]};
		total = BIG_BLOCKS ? fwp_pkg::BLOCKS_256K : fwp_pkg::BLOCKS_64K;
		n = prot_count(lvl);
		return top_bottom_select ? (blk < n) : (blk >= 10'(total - n));
	endfunction : prot_hit

	assign cs_n = st_q.s2[4];
	assign sck = st_q.s2[3];
	assign si = st_q.s2[2];
	assign wp_low = !st_q.qe && !st_q.s2[1];
	assign hold_act = !st_q.qe && !st_q.s2[0];
	assign sck_rise = sck && !st_q.sck_prev && !cs_n && !hold_act;
	assign sck_fall = !sck && st_q.sck_prev && !cs_n && !hold_act;
	assign cs_rise = cs_n && !st_q.cs_prev;
	assign cs_fall = !cs_n && st_q.cs_prev;
	assign sr_view = {st_q.lock, st_q.qe, st_q.lvl, st_q.write_enable_latch, busy_i};
	assign full_addr = {st_q.bank[fwp_pkg::BANK_A24], st_q.addr};
	assign lvl_zero = (st_q.lvl == 4'h0);

	always_comb begin
		st_d = st_q;
		st_d.s1 = {cs_n_i, sck_i, si_i, data_line_third_i, data_line_fourth_i};
		st_d.s2 = st_q.s1;
		st_d.sck_prev = sck;
		st_d.cs_prev = cs_n;
		st_d.op.valid = 1'b0;
		st_d.reject = 1'b0;
		st_d.quad = st_q.qe;
		if (cs_fall) begin
			st_d.phase = fwp_pkg::ST_OPC;
			st_d.bits = 5'h00;
			st_d.opc_ok = 1'b0;
			st_d.addr_ok = 1'b0;
			st_d.data_ok = 1'b0;
		end else if (sck_rise) begin
			st_d.bits = 5'(st_q.bits + 5'h01);
			unique case (st_q.phase)
				fwp_pkg::ST_OPC: begin
					st_d.opc = {st_q.opc[6:0], si};
					if (st_q.bits == 5'h07) begin
						st_d.opc_ok = 1'b1;
						st_d.bits = 5'h00;
						unique case (st_d.opc)
							fwp_pkg::OPC_PP, fwp_pkg::OPC_SE, fwp_pkg::OPC_SE_ALT,
							fwp_pkg::OPC_BE32, fwp_pkg::OPC_BE64: begin
								st_d.phase = fwp_pkg::ST_ADDR;
							end
							fwp_pkg::OPC_STATUS_WRITE_CMD, fwp_pkg::OPC_WRFR, fwp_pkg::OPC_PARV,
							fwp_pkg::OPC_PARV_FREE, fwp_pkg::OPC_BANKV, fwp_pkg::OPC_BANKV_FREE: begin
								st_d.phase = fwp_pkg::ST_DATA;
							end
							fwp_pkg::OPC_RDSR: begin
								st_d.phase = fwp_pkg::ST_READ;
								st_d.shift = sr_view;
							end
							default: begin
								st_d.phase = fwp_pkg::ST_SKIP;
							end
						endcase
					end
				end
				fwp_pkg::ST_ADDR: begin
					st_d.addr = {st_q.addr[22:0], si};
					if (st_q.bits == 5'h17) begin
						st_d.addr_ok = 1'b1;
						st_d.phase = fwp_pkg::ST_SKIP;
					end
				end
				fwp_pkg::ST_DATA: begin
					st_d.data = {st_q.data[6:0], si};
					if (st_q.bits == 5'h07) begin
						st_d.data_ok = 1'b1;
						st_d.phase = fwp_pkg::ST_SKIP;
					end
				end
				fwp_pkg::ST_IDLE, fwp_pkg::ST_READ, fwp_pkg::ST_SKIP: begin
				end
			endcase
		end else if (sck_fall && st_q.phase == fwp_pkg::ST_READ) begin
			// Every eighth fall takes a fresh copy of the status, so its top bit leaves at once and is not repeated.
			if (st_q.bits[2:0] == 3'h0 && st_q.bits != 5'h00) begin
				st_d.so = sr_view[7];
				st_d.shift = {sr_view[6:0], sr_view[7]};
				st_d.bits = 5'h00;
			end else begin
				st_d.so = st_q.shift[7];
				st_d.shift = {st_q.shift[6:0], st_q.shift[7]};
			end
			st_d.so_oe_n = 1'b0;
		end
		if (cs_rise) begin
			st_d.phase = fwp_pkg::ST_IDLE;
			st_d.so_oe_n = 1'b1;
			if (st_q.opc_ok && !busy_i) begin
				unique case (st_q.opc)
					fwp_pkg::OPC_WRITE_ENABLE_CMD: st_d.write_enable_latch = 1'b1;
					fwp_pkg::OPC_WRDI: st_d.write_enable_latch = 1'b0;
					fwp_pkg::OPC_STATUS_WRITE_CMD: begin
						if (st_q.data_ok && st_q.write_enable_latch && !(st_q.lock && wp_low)) begin
							st_d.lvl = st_q.data[5:2];
							st_d.qe = st_q.data[fwp_pkg::SR_QE];
							st_d.lock = st_q.data[fwp_pkg::SR_LOCK];
							st_d.write_enable_latch = 1'b0;
						end
					end
					fwp_pkg::OPC_WRFR: begin
						if (st_q.data_ok && st_q.write_enable_latch) begin
							st_d.top_bottom_select = st_q.top_bottom_select | st_q.data[fwp_pkg::FR_TBS];
							st_d.write_enable_latch = 1'b0;
						end
					end
					fwp_pkg::OPC_PARV_FREE, fwp_pkg::OPC_PARV: begin
						if (st_q.data_ok && (st_q.write_enable_latch || st_q.opc == fwp_pkg::OPC_PARV_FREE)) begin
							st_d.rdpar = st_q.data;
						end
					end
					fwp_pkg::OPC_BANKV_FREE, fwp_pkg::OPC_BANKV: begin
						if (st_q.data_ok && (st_q.write_enable_latch || st_q.opc == fwp_pkg::OPC_BANKV_FREE)) begin
							st_d.bank = st_q.data;
						end
					end
					fwp_pkg::OPC_PP, fwp_pkg::OPC_SE, fwp_pkg::OPC_SE_ALT, fwp_pkg::OPC_BE32, fwp_pkg::OPC_BE64: begin
						if (st_q.addr_ok && st_q.write_enable_latch) begin
							if (prot_hit(st_q.lvl, st_q.top_bottom_select, full_addr)) begin
								st_d.reject = 1'b1;
							end else begin
								st_d.op.valid = 1'b1;
								st_d.op.addr = full_addr;
								st_d.op.kind = (st_q.opc == fwp_pkg::OPC_PP) ? fwp_pkg::FWP_PROG :
									(st_q.opc == fwp_pkg::OPC_BE64) ? fwp_pkg::FWP_BLOCK : fwp_pkg::FWP_SECT;
								st_d.write_enable_latch = 1'b0;
							end
						end
					end
					fwp_pkg::OPC_CE, fwp_pkg::OPC_CE_ALT: begin
						if (st_q.write_enable_latch) begin
							if (lvl_zero) begin
								st_d.op.valid = 1'b1;
								st_d.op.kind = fwp_pkg::FWP_CHIP;
								st_d.op.addr = 25'h0000000;
								st_d.write_enable_latch = 1'b0;
							end else begin
								st_d.reject = 1'b1;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_q <= '0;
			st_q.s1 <= fwp_pkg::SYNC_RST;
			st_q.s2 <= fwp_pkg::SYNC_RST;
			st_q.cs_prev <= 1'b1;
			st_q.lvl <= fwp_pkg::LVL_RST;
			st_q.rdpar <= fwp_pkg::PARAM_RST;
			st_q.so_oe_n <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign so_o = st_q.so;
	assign so_oe_n_o = st_q.so_oe_n;
	// Quad transfers are handled elsewhere; these lines are only listened to here.
	assign data_line_third_o = st_q.so;
	assign data_line_third_oe_n_o = st_q.cs_prev | ~st_q.cs_prev;
	assign data_line_fourth_o = st_q.so;
	assign data_line_fourth_oe_n_o = st_q.cs_prev | ~st_q.cs_prev;
	assign op_o = st_q.op;
	assign reject_o = st_q.reject;
	assign status_o = {st_q.lock, st_q.qe, st_q.lvl, st_q.write_enable_latch, 1'b0};
	assign quad_mode_o = st_q.quad;
	assign top_bottom_select_o = st_q.top_bottom_select;
	assign read_params_o = st_q.rdpar;
	assign bank_addr_o = st_q.bank;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	a_prog_outside_range: assert property (st_q.op.valid |-> !prot_hit(st_q.lvl, st_q.top_bottom_select, st_q.op.addr))
		else $error("granted operation hits a protected block");
	a_chip_erase_clear: assert property (st_q.op.valid && st_q.op.kind == fwp_pkg::FWP_CHIP |-> $past(lvl_zero))
		else $error("whole erase granted with protection set");
	a_status_lock_hold: assert property (st_q.lock && wp_low |=> $stable({st_q.lock, st_q.qe, st_q.lvl}))
		else $error("locked status bits changed");
	a_status_needs_wel: assert property ($changed({st_q.lock, st_q.qe, st_q.lvl}) |-> $past(st_q.write_enable_latch) && !st_q.write_enable_latch)
		else $error("status changed without write enable");
	a_selector_sticky: assert property ($past(st_q.top_bottom_select) |-> st_q.top_bottom_select)
		else $error("selector returned to top");
	a_params_free_cmd: assert property ($changed(st_q.rdpar) |-> $past(st_q.write_enable_latch) || $past(st_q.opc) == fwp_pkg::OPC_PARV_FREE)
		else $error("parameter write without enable or free code");
	a_top_level_one: assert property (st_q.op.valid && !st_q.top_bottom_select && st_q.lvl == 4'h1 && !BIG_BLOCKS
		|-> st_q.op.addr[24:16] != 9'h1FF)
		else $error("top block written at level one");
	a_bottom_level_one: assert property (st_q.op.valid && st_q.top_bottom_select && st_q.lvl == 4'h1 && st_q.op.kind != fwp_pkg::FWP_CHIP
		|-> st_q.op.addr[24:16] != 9'h000)
		else $error("bottom block written at level one");
	a_hold_in_quad: assert property (st_q.qe |-> !hold_act && !wp_low)
		else $error("control pin active in quad mode");
	a_wel_after_grant: assert property (st_q.op.valid |-> !st_q.write_enable_latch)
		else $error("write enable still set after a granted operation");
	c_grant: cover property (st_q.op.valid);
	c_reject: cover property (st_q.reject);
	c_locked_write: cover property (cs_rise && st_q.opc == fwp_pkg::OPC_STATUS_WRITE_CMD && st_q.lock && wp_low);
	c_bottom_set: cover property ($rose(st_q.top_bottom_select));
endmodule : fwp_core

/* File: bench/fwp_host.sv */
// Purpose: Behavioural serial host that frames commands on the link pins.
// Assumes: Mode 0 link, clock idle low, 125 ns bit period.
// Notes: Data in is inverted on release so a stale bit never looks driven.
`timescale 1ns/1ns
module fwp_host (
	// Link pins.
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end

	// Sends the top n bits MSB first; rd keeps the last eight bits seen at the rises.
	task automatic xfer(input logic [31:0] bits, input int n, output logic [7:0] rd);
		rd = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			si_o = bits[31 - i];
			#63 sck_o = 1'b1;
			rd = {rd[6:0], so_i};
			#62 sck_o = 1'b0;
		end
		#63 cs_n_o = 1'b1;
		si_o = ~si_o;
		#100;
	endtask : xfer
endmodule : fwp_host

/* File: bench/fwp_core_bench.sv */
// Purpose: Self-checking bench of the write-protection block.
// Assumes: Small block geometry; host frames commands on the link.
// Notes: Grants and refusals are counted from the one-cycle pulses.
`timescale 1ns/1ns
module fwp_core_bench;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic sck, cs_n, si, so, so_oe_n, so_line;
	logic protect_n = 1'b0;
	logic hold_n = 1'b1;
	fwp_pkg::fwp_op_t op, last_op;
	logic reject, quad, top_bottom_select, third_oe_n, fourth_oe_n;
	logic [7:0] status, rpar, bank, rd;
	int bad_count = 0;
	int tests_run = 0;
	int grants = 0;
	int rejects = 0;
	int g0, n;
	logic bank_q = 1'b0;
	logic [7:0] opcs [5] = '{fwp_pkg::OPC_PP, fwp_pkg::OPC_SE, fwp_pkg::OPC_SE_ALT, fwp_pkg::OPC_BE32,
		fwp_pkg::OPC_BE64};
	logic [1:0] kinds [5] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2};

	always #2 clk_i = ~clk_i;
	assign so_line = so_oe_n ? ~so : so;

	fwp_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_line));
	fwp_core #(.BIG_BLOCKS(1'b0)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
		.si_i(si), .so_o(so), .so_oe_n_o(so_oe_n), .data_line_third_i(protect_n), .data_line_third_o(),
		.data_line_third_oe_n_o(third_oe_n), .data_line_fourth_i(hold_n), .data_line_fourth_o(),
		.data_line_fourth_oe_n_o(fourth_oe_n), .busy_i(1'b0), .op_o(op), .reject_o(reject),
		.status_o(status), .quad_mode_o(quad), .top_bottom_select_o(top_bottom_select), .read_params_o(rpar),
		.bank_addr_o(bank));

	always @(negedge clk_i) begin
		if (op.valid === 1'b1) begin
			grants++;
			last_op = op;
		end
		if (reject === 1'b1) begin
			rejects++;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic send(input logic [31:0] bits, input int nb);
		host.xfer(bits, nb, rd);
	endtask : send

	task automatic wsr(input logic [7:0] d);
		send({fwp_pkg::OPC_WRITE_ENABLE_CMD, 24'h0}, 8);
		send({fwp_pkg::OPC_STATUS_WRITE_CMD, d, 16'h0}, 16);
	endtask : wsr

	// Programs or erases the first page of a block and checks grant or refusal.
	task automatic prog(input int k, input logic [8:0] blk, input logic g);
		int r0;
		if (blk[8] !== bank_q) begin
			send({fwp_pkg::OPC_BANKV_FREE, 7'h00, blk[8], 16'h0}, 16);
			bank_q = blk[8];
		end
		send({fwp_pkg::OPC_WRITE_ENABLE_CMD, 24'h0}, 8);
		g0 = grants;
		r0 = rejects;
		send({opcs[k], blk[7:0], 16'h0}, 32);
		chk(grants - g0, {31'h0, g});
		chk(rejects - r0, {31'h0, !g});
		if (g) begin
			chk({last_op.kind, last_op.addr}, {kinds[k], blk, 16'h0});
		end
	endtask : prog

	function automatic int cnt(input int l);
		if (l == 15) return 512;
		if (l > 9) return 512 - (512 >> (l - 8));
		return 1 << (l - 1);
	endfunction : cnt

	task automatic complete_run;
		$display("Checks run %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	initial begin
		#380000;
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (5) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		chk(status, 8'h00);
		chk({quad, top_bottom_select, third_oe_n, fourth_oe_n}, 4'h3);
		send({fwp_pkg::OPC_PARV_FREE, 8'hA5, 16'h0}, 16);
		chk(rpar, 8'hA5);
		send({fwp_pkg::OPC_BANKV_FREE, 8'h01, 16'h0}, 16);
		bank_q = 1'b1;
		chk(bank, 8'h01);
		send({fwp_pkg::OPC_PARV, 8'h3C, 16'h0}, 16);
		chk(rpar, 8'hA5);
		g0 = grants;
		send({fwp_pkg::OPC_PP, 24'h123456}, 32);
		chk(grants - g0, 0);
		send({fwp_pkg::OPC_WRITE_ENABLE_CMD, 24'h0}, 8);
		send({fwp_pkg::OPC_CE_ALT, 24'h0}, 8);
		chk({30'(grants - g0), last_op.kind}, {30'h1, 2'h3});
		for (int l = 1; l < 16; l++) begin
			n = cnt(l);
			wsr({2'h0, 4'(l), 2'h0});
			chk(status, {2'h0, 4'(l), 2'h0});
			prog(l % 5, 9'(512 - n), 1'b0);
			if (n < 512) begin
				prog((l + 1) % 5, 9'(511 - n), 1'b1);
			end
		end
		send({fwp_pkg::OPC_WRITE_ENABLE_CMD, 24'h0}, 8);
		g0 = grants;
		send({fwp_pkg::OPC_CE, 24'h0}, 8);
		chk(grants - g0, 0);
		wsr(8'hBC);
		send({fwp_pkg::OPC_RDSR, 24'h0}, 16);
		chk(rd, 8'hBC);
		send({fwp_pkg::OPC_RDSR, 24'h0}, 24);
		chk(rd, 8'hBC);
		wsr(8'h00);
		chk(status, 8'hBE);
		@(negedge clk_i) protect_n = 1'b1;
		wsr(8'h40);
		chk({status, quad}, {8'h40, 1'b1});
		@(negedge clk_i) protect_n = 1'b0;
		wsr(8'hC0);
		@(negedge clk_i) hold_n = 1'b0;
		wsr(8'h00);
		chk({status, quad}, 9'h000);
		send({fwp_pkg::OPC_WRITE_ENABLE_CMD, 24'h0}, 8);
		chk(status[1], 1'b0);
		@(negedge clk_i) hold_n = 1'b1;
		send({fwp_pkg::OPC_WRITE_ENABLE_CMD, 24'h0}, 8);
		send({fwp_pkg::OPC_WRFR, 8'h02, 16'h0}, 16);
		chk(top_bottom_select, 1'b1);
		send({fwp_pkg::OPC_WRITE_ENABLE_CMD, 24'h0}, 8);
		send({fwp_pkg::OPC_WRFR, 8'h00, 16'h0}, 16);
		chk(top_bottom_select, 1'b1);
		for (int l = 1; l < 13; l += 5) begin
			n = cnt(l);
			wsr({2'h0, 4'(l), 2'h0});
			prog(l % 5, 9'(n - 1), 1'b0);
			prog(4, 9'(n), 1'b1);
		end
		complete_run();
	end
endmodule : fwp_core_bench
